// [fec_sync_header_rx.sv]
// Receive end: syndrome check, block/multiblock/extended alignment, elastic buffer.
// Assumes blocks arrive already framed on lnk; one lane; same block clock as sender.
`timescale 1ns/1ps
`default_nettype none
`include "sync_hdr_defs.svh"
module sync_fifo #(
  parameter int W = 64,
  parameter int D = 32
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;

  assign in_ready  = ~((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid = (wp_q != rp_q);
  assign out_data  = mem[rp_q[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid && in_ready) wp_q <= wp_q + {{AW{1'h0}}, 1'h1};
      if (out_valid && out_ready) rp_q <= rp_q + {{AW{1'h0}}, 1'h1};
    end
  end
endmodule : sync_fifo

module fec_sync_header_rx
  import sync_hdr_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  sync_hdr_if.rx                 lnk,
  input  wire logic              sysref,
  input  wire logic [1:0]        sync_header_mode_sel,
  input  wire logic              enc_8b10b,
  input  wire logic              ilas_seen,
  input  wire logic [`E_W-1:0]   emb_len_m1,
  input  wire logic [`LEMC_W-1:0] rbd,
  input  wire logic              out_ready,
  output logic                   out_valid,
  output logic [63:0]            out_data,
  output logic                   eb_ready,
  output logic                   blk_lock,
  output logic                   mb_lock,
  output logic                   emb_lock,
  output logic                   released,
  output logic                   sysref_req_q,
  output logic                   fec_err_q,
  output logic [25:0]            syndrome_q
);

  sync_e             st_q;
  eb_e               eb_q;
  logic [31:0]       sr_q;
  logic [31:0]       sr_d;
  logic [4:0]        blk_q;
  logic [`E_W-1:0]   mb_q;
  logic [5:0]        good_q;
  logic [2:0]        mbgood_q;
  logic [5:0]        swin_q;
  logic [4:0]        serr_q;
  logic [4:0]        serr_n;
  logic [3:0]        mwin_q;
  logic [2:0]        merr_q;
  logic [2:0]        merr_n;
  logic [2:0]        ewin_q;
  logic [1:0]        eerr_q;
  logic [1:0]        eerr_n;
  logic              eflag_q;
  logic [25:0]       acc_q;
  logic [25:0]       acc_d;
  logic [25:0]       calc_q;
  logic              have_q;
  logic [`LEMC_W-1:0] lemc_q;
  logic              v;
  logic              hdr_ok;
  logic              pilot_ok;
  logic              mb_end;
  logic              eoemb_exp;
  logic              eoemb_bad;
  logic              blk_lost;
  logic              in_sync;
  logic              fec_on;
  logic              emb_start;
  logic              eb_lost;
  logic              wr_en;
  logic              fifo_v;

  assign v         = lnk.blk_valid;
  assign hdr_ok    = lnk.sh[1] ^ lnk.sh[0];
  assign sr_d      = {lnk.sh == `SH_ONE, sr_q[31:1]};
  assign pilot_ok  = (sr_d[31:27] == `PILOT);
  assign mb_end    = (blk_q == `MB_LAST);
  assign eoemb_exp = (mb_q == emb_len_m1);
  assign eoemb_bad = (sr_d[`EOEMB_BIT] != eoemb_exp);
  assign in_sync   = (st_q == S_EMB) || (st_q == S_LOCK);
  assign fec_on    = (sync_header_mode_sel == `SH_MODE_FEC);
  assign serr_n    = serr_q + {4'h0, ~hdr_ok};
  assign blk_lost  = v && (st_q != S_BLK) && (serr_n == `SH_ERR_MAX);
  assign merr_n    = merr_q + {2'h0, ~pilot_ok};
  assign eerr_n    = eerr_q + {1'h0, eflag_q | eoemb_bad};
  assign blk_lock  = (st_q != S_BLK);
  assign mb_lock   = in_sync;
  assign emb_lock  = (st_q == S_LOCK);

  always_ff @(posedge mclk) begin
    if (rst) sr_q <= 32'h0;
    else if (v) sr_q <= sr_d;
  end

  // Header error window; up to 15 bad headers in 64 blocks are tolerated, the 16th drops block lock
  always_ff @(posedge mclk) begin
    if (rst || (st_q == S_BLK)) begin
      swin_q <= 6'h0;
      serr_q <= 5'h0;
    end else if (v) begin
      swin_q <= swin_q + 6'h1;
      serr_q <= (swin_q == `SH_WIN_LAST) ? 5'h0 : serr_n;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q         <= S_BLK;
      blk_q        <= 5'h0;
      mb_q         <= '0;
      good_q       <= 6'h0;
      mbgood_q     <= 3'h0;
      mwin_q       <= 4'h0;
      merr_q       <= 3'h0;
      ewin_q       <= 3'h0;
      eerr_q       <= 2'h0;
      eflag_q      <= 1'h0;
      sysref_req_q <= 1'h0;
    end else begin
      sysref_req_q <= 1'h0;
      if (v) begin
        blk_q <= blk_q + 5'h1;
        if (mb_end) mb_q <= eoemb_exp ? '0 : mb_q + {{(`E_W-1){1'h0}}, 1'h1};
        case (st_q)
          S_BLK: begin
            good_q   <= hdr_ok ? good_q + 6'h1 : 6'h0;
            mbgood_q <= 3'h0;
            if (hdr_ok && (good_q == `BLK_LOCK_LAST)) st_q <= S_MB;
          end
          S_MB: begin
            if (mbgood_q == 3'h0) begin
              if (pilot_ok) begin
                blk_q    <= 5'h0;
                mbgood_q <= 3'h1;
              end
            end else if (mb_end) begin
              if (!pilot_ok) mbgood_q <= 3'h0;
              else if (mbgood_q == `MB_CONFIRM_LAST) st_q <= S_EMB;
              else mbgood_q <= mbgood_q + 3'h1;
            end
          end
          S_EMB: begin
            if (mb_end && !pilot_ok) begin
              st_q         <= S_MB;
              mbgood_q     <= 3'h0;
              sysref_req_q <= 1'h1;
            end else if (mb_end && sr_d[`EOEMB_BIT]) begin
              mb_q    <= '0;
              st_q    <= S_LOCK;
              mwin_q  <= 4'h0;
              merr_q  <= 3'h0;
              ewin_q  <= 3'h0;
              eerr_q  <= 2'h0;
              eflag_q <= 1'h0;
            end
          end
          S_LOCK: begin
            if (mb_end) begin
              mwin_q  <= mwin_q + 4'h1;
              merr_q  <= (mwin_q == `MB_WIN_LAST) ? 3'h0 : merr_n;
              eflag_q <= eoemb_exp ? 1'h0 : (eflag_q | eoemb_bad);
              if (eoemb_exp) begin
                ewin_q <= ewin_q + 3'h1;
                eerr_q <= (ewin_q == `EMB_WIN_LAST) ? 2'h0 : eerr_n;
              end
              if (merr_n == `MB_ERR_MAX) begin
                st_q         <= S_MB;
                mbgood_q     <= 3'h0;
                sysref_req_q <= 1'h1;
              end else if (eoemb_exp && (eerr_n == `EMB_ERR_MAX)) begin
                st_q         <= S_EMB;
                sysref_req_q <= 1'h1;
              end
            end
          end
          default: st_q <= S_BLK;
        endcase
        if (blk_lost) begin
          st_q   <= S_BLK;
          good_q <= 6'h0;
        end
      end
    end
  end

  // Local parity of each aligned multiblock, checked against the next stream
  assign acc_d = par_step((blk_q == 5'h0) ? 26'h0 : acc_q, lnk.payload,
                          `FEC_POLY, `FEC_W);

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_q      <= 26'h0;
      calc_q     <= 26'h0;
      have_q     <= 1'h0;
      syndrome_q <= 26'h0;
      fec_err_q  <= 1'h0;
    end else begin
      fec_err_q <= 1'h0;
      if (v) begin
        acc_q <= acc_d;
        if (mb_end) begin
          calc_q <= acc_d;
          have_q <= in_sync && fec_on;
          if (have_q && in_sync && fec_on) begin
            syndrome_q <= fec_par_of(sr_d) ^ calc_q;
            fec_err_q  <= |(fec_par_of(sr_d) ^ calc_q);
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || sysref) lemc_q <= '0;
    else if (lemc_q == {emb_len_m1, `MB_LAST}) lemc_q <= '0;
    else lemc_q <= lemc_q + {{(`LEMC_W-1){1'h0}}, 1'h1};
  end

  assign emb_start = (st_q == S_LOCK) && (blk_q == 5'h0) && (mb_q == '0);
  assign eb_lost   = !enc_8b10b && (st_q != S_LOCK);

  always_ff @(posedge mclk) begin
    if (rst) begin
      eb_q <= EB_IDLE;
    end else begin
      case (eb_q)
        EB_IDLE: begin
          if (enc_8b10b && ilas_seen) eb_q <= EB_FILL;
          else if (!enc_8b10b && (st_q == S_LOCK)) eb_q <= EB_WAIT;
        end
        EB_WAIT: begin
          if (eb_lost || enc_8b10b) eb_q <= EB_IDLE;
          else if (v && emb_start) eb_q <= EB_FILL;
        end
        EB_FILL: begin
          if (eb_lost) eb_q <= EB_IDLE;
          else if (lemc_q == rbd) eb_q <= EB_RUN;
        end
        EB_RUN: begin
          if (eb_lost) eb_q <= EB_IDLE;
        end
        default: eb_q <= EB_IDLE;
      endcase
    end
  end

  assign wr_en     = v && (((eb_q == EB_WAIT) && emb_start && !eb_lost && !enc_8b10b) ||
                           (eb_q == EB_FILL) || (eb_q == EB_RUN));
  assign released  = (eb_q == EB_RUN);
  assign out_valid = fifo_v && released;

  sync_fifo #(
    .W (`PAYLOAD_W),
    .D (`EB_DEPTH)
  ) u_ebuf (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (eb_q == EB_IDLE),
    .in_valid  (wr_en),
    .in_ready  (eb_ready),
    .in_data   (lnk.payload),
    .out_valid (fifo_v),
    .out_ready (out_ready && released),
    .out_data  (out_data)
  );

endmodule : fec_sync_header_rx
`default_nettype wire

// [sync_hdr_defs.svh]
// Constants for the 64B/66B sync-header-stream link: layout, polynomials, counts.
// Assumes inclusion by bare name from every file of the link.
`ifndef SYNC_HDR_DEFS_SVH
`define SYNC_HDR_DEFS_SVH

`define PAYLOAD_W      64
`define SHS_W          32
`define FEC_W          26
`define CRC_W          12
`define PE_W           4
`define E_W            5
`define LEMC_W         10
`define EB_DEPTH       32

`define SH_MODE_CRC12  2'h0
`define SH_MODE_FEC    2'h2
`define SH_ONE         2'h1
`define SH_ZERO        2'h2

`define FEC_POLY       26'h0220211
`define CRC_POLY       26'h000030F
`define CRC_SHS_BASE   32'h80A88888
`define EOEMB_BIT      22
`define PILOT          5'h10
`define MB_LAST        5'h1F

`define BLK_LOCK_LAST  6'h3F
`define SH_WIN_LAST    6'h3F
`define SH_ERR_MAX     5'h10
`define MB_CONFIRM_LAST 3'h3
`define MB_WIN_LAST    4'hF
`define MB_ERR_MAX     3'h4
`define EMB_WIN_LAST   3'h7
`define EMB_ERR_MAX    2'h2

`endif

// [sync_hdr_pkg.sv]
// Types and shared parity and stream-mapping functions for both link ends.
// Assumes sync_hdr_defs.svh is on the include path.
`include "sync_hdr_defs.svh"
package sync_hdr_pkg;

  typedef enum logic [3:0] {
    S_BLK  = 4'h1,
    S_MB   = 4'h2,
    S_EMB  = 4'h4,
    S_LOCK = 4'h8
  } sync_e;

  typedef enum logic [3:0] {
    EB_IDLE = 4'h1,
    EB_WAIT = 4'h2,
    EB_FILL = 4'h4,
    EB_RUN  = 4'h8
  } eb_e;

  // Serial division, one bit at a time, payload bit 0 first
  function automatic logic [25:0] par_step(input logic [25:0] s, input logic [63:0] d,
                                           input logic [25:0] poly, input int unsigned w);
    logic [25:0] r;
    logic        fb;
    r = s;
    for (int i = 0; i < 64; i++) begin
      fb = r[w-1] ^ d[i];
      r  = {r[24:0], 1'h0} & ~(26'h1 << w);
      if (fb) r = r ^ poly;
    end
    return r;
  endfunction : par_step

  function automatic logic [31:0] fec_stream(input logic [25:0] p, input logic e);
    logic [31:0] s;
    s = 32'h80000000;
    for (int i = 0; i < 22; i++) s[i] = p[25-i];
    s[`EOEMB_BIT] = e;
    s[23] = p[3];
    s[24] = p[2];
    s[25] = p[1];
    s[26] = p[0];
    return s;
  endfunction : fec_stream

  function automatic logic [25:0] fec_par_of(input logic [31:0] s);
    logic [25:0] p;
    p = 26'h0;
    for (int i = 0; i < 22; i++) p[25-i] = s[i];
    p[3] = s[23];
    p[2] = s[24];
    p[1] = s[25];
    p[0] = s[26];
    return p;
  endfunction : fec_par_of

  function automatic logic [31:0] crc_stream(input logic [11:0] c, input logic e);
    logic [31:0] s;
    s = `CRC_SHS_BASE;
    s[0]  = c[11];
    s[1]  = c[10];
    s[2]  = c[9];
    s[4]  = c[8];
    s[5]  = c[7];
    s[6]  = c[6];
    s[8]  = c[5];
    s[9]  = c[4];
    s[10] = c[3];
    s[12] = c[2];
    s[13] = c[1];
    s[14] = c[0];
    s[`EOEMB_BIT] = e;
    return s;
  endfunction : crc_stream

endpackage : sync_hdr_pkg

// [sync_hdr_if.sv]
// One lane carrying a 66-bit block per clock: two-bit sync header plus payload.
// Assumes both ends run on the same block clock; sh[1] is the first bit on the line.
`timescale 1ns/1ps
`default_nettype none
`include "sync_hdr_defs.svh"
interface sync_hdr_if;
  logic                  blk_valid;
  logic [1:0]            sh;
  logic [`PAYLOAD_W-1:0] payload;

  modport tx (output blk_valid, output sh, output payload);
  modport rx (input blk_valid, input sh, input payload);
endinterface : sync_hdr_if
`default_nettype wire

// [fec_sync_header_tx.sv]
// Transmit end: sync-header-stream generation with FEC or CRC-12 parity and pilot.
// Assumes scrambled payload at the user port; one block leaves every clock.
`timescale 1ns/1ps
`default_nettype none
`include "sync_hdr_defs.svh"
module fec_sync_header_tx
  import sync_hdr_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  sync_hdr_if.tx                 lnk,
  input  wire logic              sysref,
  input  wire logic [1:0]        sync_header_mode_sel,
  input  wire logic [`E_W-1:0]   emb_len_m1,
  input  wire logic [`PE_W-1:0]  serializer_preemph_level,
  input  wire logic [63:0]       in_data,
  input  wire logic              in_valid,
  output logic                   in_ready,
  output logic [`PE_W-1:0]       preemph_drive_q
);

  logic [4:0]        blk_q;
  logic [`E_W-1:0]   mb_q;
  logic [25:0]       acc_q;
  logic [25:0]       acc_d;
  logic [25:0]       par_q;
  logic [63:0]       data;
  logic              fec_on;
  logic              eoemb;
  logic [31:0]       stream;

  assign in_ready = ~rst;
  assign data     = in_valid ? in_data : 64'h0;
  assign fec_on   = (sync_header_mode_sel == `SH_MODE_FEC);
  assign eoemb    = (mb_q == emb_len_m1);

  // Stages start from zero at block 0; headers never enter
  assign acc_d = fec_on ?
      par_step((blk_q == 5'h0) ? 26'h0 : acc_q, data, `FEC_POLY, `FEC_W) :
      par_step((blk_q == 5'h0) ? 26'h0 : acc_q, data, `CRC_POLY, `CRC_W);

  // Parity of the previous multiblock rides in this one's stream
  assign stream = fec_on ? fec_stream(par_q, eoemb) :
                           crc_stream(par_q[11:0], eoemb);

  // Block position and LEMC phase, restarted by SYSREF
  always_ff @(posedge mclk) begin
    if (rst || sysref) begin
      blk_q <= 5'h0;
      mb_q  <= '0;
    end else begin
      blk_q <= blk_q + 5'h1;
      if (blk_q == `MB_LAST) begin
        mb_q <= eoemb ? '0 : mb_q + {{(`E_W-1){1'h0}}, 1'h1};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_q <= 26'h0;
      par_q <= 26'h0;
    end else begin
      acc_q <= acc_d;
      if (blk_q == `MB_LAST) begin
        par_q <= acc_d;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lnk.blk_valid <= 1'h0;
      lnk.sh        <= `SH_ZERO;
      lnk.payload   <= '0;
    end else begin
      lnk.blk_valid <= 1'h1;
      lnk.sh        <= stream[blk_q] ? `SH_ONE : `SH_ZERO;
      lnk.payload   <= data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      preemph_drive_q <= '0;
    end else begin
      preemph_drive_q <= serializer_preemph_level;
    end
  end

endmodule : fec_sync_header_tx
`default_nettype wire

// [fec_sync_header_lane_align_monitor.sv]
// Checker for the sync-header link between the transmit and receive ends.
// Assumes mode and E are changed only at a multiblock boundary.
`timescale 1ns/1ps
`default_nettype none
module fec_sync_header_lane_align_monitor (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        sysref,
  input  wire logic [1:0]  sync_header_mode_sel,
  input  wire logic [4:0]  emb_len_m1,
  input  wire logic [63:0] in_data,
  input  wire logic        in_valid,
  input  wire logic        blk_valid,
  input  wire logic [1:0]  sh,
  input  wire logic [63:0] payload
);
  logic [4:0]  idx_q;
  logic [4:0]  mb_q;
  logic [25:0] acc_q;
  logic [25:0] prev_q;
  logic        run_q;
  logic        have_q;
  logic        exp_bit;
  logic        act;
  logic        fec;

  // Serial division of one block, payload bit 0 first
  function automatic logic [25:0] step(input logic [25:0] s, input logic [63:0] d);
    logic [25:0] r;
    r = s;
    for (int i = 0; i < 64; i++) begin
      r = (r[25] ^ d[i]) ? ({r[24:0], 1'h0} ^ 26'h0220211) : {r[24:0], 1'h0};
    end
    return r;
  endfunction : step

  assign act = blk_valid && run_q;
  assign fec = sync_header_mode_sel == 2'h2;

  always_ff @(posedge mclk) begin
    if (rst || sysref) begin
      idx_q <= 5'h1F;
      mb_q  <= emb_len_m1;
    end else begin
      idx_q <= idx_q + 5'h01;
      if (idx_q == 5'h1F) begin
        mb_q <= (mb_q == emb_len_m1) ? 5'h00 : mb_q + 5'h01;
      end
    end
  end

  // Parity of the previous whole multiblock; the first one after a restart is skipped
  always_ff @(posedge mclk) begin
    if (rst || sysref) begin
      acc_q  <= 26'h0;
      run_q  <= 1'b0;
      have_q <= 1'b0;
    end else if (idx_q == 5'h1F) begin
      acc_q  <= 26'h0;
      prev_q <= step(acc_q, payload);
      run_q  <= 1'b1;
      have_q <= run_q;
    end else begin
      acc_q <= step(acc_q, payload);
    end
  end

  always_comb begin
    exp_bit = (idx_q < 5'h16) ? prev_q[5'h19 - idx_q] : prev_q[5'h1A - idx_q];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || sysref);

  a_sh_legal: assert property (blk_valid |-> sh inside {2'h1, 2'h2})
    else $error("sync header not 01 or 10");
  a_link_steady: assert property (!$past(rst) |-> blk_valid)
    else $error("block missing on the link");
  a_pilot_zeros: assert property (act && idx_q inside {[5'h1B:5'h1E]} |-> sh == 2'h2)
    else $error("pilot zero bit wrong");
  a_stream_end: assert property (act && idx_q == 5'h1E |=> act && sh == 2'h1)
    else $error("last stream bit not one");
  a_eoemb_place: assert property (act && idx_q == 5'h16 |-> (sh == 2'h1) == (mb_q == emb_len_m1))
    else $error("end of extended multiblock flag misplaced");
  a_fec_parity: assert property (act && fec && have_q
    && idx_q <= 5'h1A && idx_q != 5'h16 |-> (sh == 2'h1) == exp_bit)
    else $error("parity bit in stream wrong");
  a_crc_ones: assert property (act && !fec
    && idx_q inside {5'h03, 5'h07, 5'h0B, 5'h0F, 5'h13, 5'h15, 5'h17} |-> sh == 2'h1)
    else $error("fixed one missing in crc stream");
  a_payload_next: assert property (!$past(rst)
    |-> payload == ($past(in_valid) ? $past(in_data) : 64'h0))
    else $error("payload not the word taken one cycle before");

  c_parity: cover property (act && fec && have_q && idx_q == 5'h00);
  c_eoemb: cover property (act && idx_q == 5'h16 && sh == 2'h1);
  c_crc: cover property (act && !fec && idx_q == 5'h03);
endmodule : fec_sync_header_lane_align_monitor
`default_nettype wire

// [fec_sync_header_lane_align_tb.sv]
// Testbench: one transmitter, a receiver on its link, a second receiver on a damaged copy.
// Assumes the design files are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
module fec_sync_header_lane_align_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        sysref = 1'b0;
  logic [1:0]  mode = 2'h2;
  logic [4:0]  eml = 5'h01;
  logic [9:0]  rbd = 10'h005;
  logic [3:0]  pe = 4'h0;
  logic [63:0] din = 64'h0;
  logic        dval = 1'b0;
  logic        ordy = 1'b0;
  logic        bad_pl = 1'b0;
  logic        bad_all = 1'b0;
  logic        bad_on = 1'b0;
  logic [4:0]  bad_idx = 5'h1F;
  logic [4:0]  tidx = 5'h1F;
  logic        req_seen = 1'b0;
  logic        enc8 = 1'b0;
  logic        ilas = 1'b0;
  int          fail_count = 0;
  int          total_checks = 0;
  int          n;
  logic [3:0]  drive;
  logic [63:0] od;
  logic [25:0] syn;
  logic [25:0] syn2;
  logic        ir, ov, ebr, bl, ml, el, rel, fe, bl2, ml2, el2, srq2, fe2, rel2;
  logic [9:0]  ev;

  sync_hdr_if lnk ();
  sync_hdr_if lnk2 ();
  fec_sync_header_tx i_fec_sync_header_tx (.mclk(mclk), .rst(rst), .lnk(lnk), .sysref(sysref),
    .sync_header_mode_sel(mode), .emb_len_m1(eml), .serializer_preemph_level(pe),
    .in_data(din), .in_valid(dval), .in_ready(ir), .preemph_drive_q(drive));
  fec_sync_header_rx i_fec_sync_header_rx (.mclk(mclk), .rst(rst), .lnk(lnk), .sysref(sysref),
    .sync_header_mode_sel(mode), .enc_8b10b(1'b0), .ilas_seen(1'b0), .emb_len_m1(eml),
    .rbd(rbd), .out_ready(ordy), .out_valid(ov), .out_data(od), .eb_ready(ebr), .blk_lock(bl),
    .mb_lock(ml), .emb_lock(el), .released(rel), .sysref_req_q(), .fec_err_q(fe),
    .syndrome_q(syn));
  fec_sync_header_rx i_fec_sync_header_rx2 (.mclk(mclk), .rst(rst), .lnk(lnk2), .sysref(sysref),
    .sync_header_mode_sel(mode), .enc_8b10b(enc8), .ilas_seen(ilas), .emb_len_m1(eml),
    .rbd(rbd), .out_ready(ordy), .out_valid(), .out_data(), .eb_ready(), .blk_lock(bl2),
    .mb_lock(ml2), .emb_lock(el2), .released(rel2), .sysref_req_q(srq2), .fec_err_q(fe2),
    .syndrome_q(syn2));
  fec_sync_header_lane_align_monitor i_fec_sync_header_lane_align_monitor (.mclk(mclk),
    .rst(rst), .sysref(sysref), .sync_header_mode_sel(mode), .emb_len_m1(eml), .in_data(din),
    .in_valid(dval), .blk_valid(lnk.blk_valid), .sh(lnk.sh), .payload(lnk.payload));

  // Damaged copy of the link for the second receiver
  always_comb begin
    lnk2.blk_valid = lnk.blk_valid;
    lnk2.payload   = lnk.payload ^ {63'h0, bad_pl && tidx == 5'h00};
    lnk2.sh        = bad_all ? 2'h3 : ((bad_on && tidx == bad_idx) ? ~lnk.sh : lnk.sh);
  end

  assign ev = {rel2, tidx == 5'h1F, ~bl2, ~ml2, ~el2, el2, fe2, ~ebr, rel, el};
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) tidx <= (rst || sysref) ? 5'h1F : tidx + 5'h01;
  always @(posedge mclk) din <= #2 din + 64'h1;
  always @(posedge mclk) if (srq2) req_seen <= 1'b1;

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask : cyc

  task automatic wait_ev(input int b, input int lim, input string nm, output int cnt);
    cnt = 0;
    while (ev[b] !== 1'b1) begin
      if (cnt == lim) begin
        fail_count++;
        $display("[FAIL] %s expected 1 seen 0", nm);
        close_out();
      end
      cyc(1);
      cnt++;
    end
  endtask : wait_ev

  task automatic resync;
    sysref = 1'b1;
    cyc(1);
    sysref = 1'b0;
    wait_ev(4, 3000, "second rx lock", n);
  endtask : resync

  task automatic t_preemph;
    for (int lv = 0; lv < 16; lv++) begin
      pe = lv[3:0];
      dval = lv[0];
      cyc(2);
      chk("preemph drive", 64'(drive), 64'(lv));
    end
    dval = 1'b1;
  endtask : t_preemph

  task automatic t_lock;
    resync();
    wait_ev(0, 3000, "rx lock", n);
    chk("block lock", 64'(bl), 64'h1);
    chk("multiblock lock", 64'(ml), 64'h1);
    chk("early out valid", 64'(ov), 64'h0);
    cyc(96);
    chk("error flag", 64'(fe), 64'h0);
    chk("syndrome", 64'(syn), 64'h0);
    chk("in ready", 64'(ir), 64'h1);
  endtask : t_lock

  task automatic t_buffer;
    logic [63:0] first;
    wait_ev(1, 3000, "release", n);
    wait_ev(2, 200, "buffer full", n);
    chk("out valid when full", 64'(ov), 64'h1);
    first = od;
    ordy = 1'b1;
    for (int k = 1; k < 31; k++) begin
      cyc(1);
      chk("buffer order", od, first + 64'(k));
    end
  endtask : t_buffer

  task automatic t_fec_err;
    wait_ev(8, 40, "multiblock end", n);
    bad_pl = 1'b1;
    cyc(2);
    bad_pl = 1'b0;
    wait_ev(3, 200, "parity error", n);
    chk("error latency", 64'(n >= 57 && n <= 70), 64'h1);
    chk("syndrome nonzero", 64'(syn2 != 26'h0), 64'h1);
    chk("clean rx error", 64'(fe), 64'h0);
  endtask : t_fec_err

  task automatic t_stream_err(input logic [4:0] bi, input int b);
    req_seen = 1'b0;
    bad_idx = bi;
    bad_on = 1'b1;
    wait_ev(b, 1500, "alignment loss", n);
    cyc(2);
    chk("sysref request", 64'(req_seen), 64'h1);
    bad_on = 1'b0;
    resync();
  endtask : t_stream_err

  task automatic t_hdr;
    bad_all = 1'b1;
    cyc(1);
    bad_all = 1'b0;
    cyc(70);
    chk("lock after one bad header", 64'(bl2), 64'h1);
    bad_all = 1'b1;
    wait_ev(7, 100, "block lock loss", n);
    bad_all = 1'b0;
  endtask : t_hdr

  // 8B/10B buffering on the damaged-link receiver: no release without a start pulse
  task automatic t_ilas;
    cyc(2);
    enc8 = 1'b1;
    cyc(70);
    chk("release before start pulse", 64'(rel2), 64'h0);
    ilas = 1'b1;
    cyc(1);
    ilas = 1'b0;
    wait_ev(9, 70, "release after start pulse", n);
    enc8 = 1'b0;
  endtask : t_ilas

  task automatic t_crc(input logic [1:0] m);
    wait_ev(8, 40, "multiblock end", n);
    mode = m;
    cyc(4);
    chk("crc fixed one", 64'(lnk.sh), 64'h1);
    cyc(64);
  endtask : t_crc

  initial begin
    repeat (3) @(posedge mclk);
    #2;
    rst = 1'b0;
    t_preemph();
    t_lock();
    t_buffer();
    t_fec_err();
    t_stream_err(5'h1F, 6);
    t_stream_err(5'h16, 5);
    t_hdr();
    t_ilas();
    t_crc(2'h0);
    t_crc(2'h3);
    close_out();
  end
endmodule : fec_sync_header_lane_align_tb
`default_nettype wire
